// file: hdl/mzc_top.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
module mzc_top (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire mzc_pkg::mzc_apb_req_type apb_req,
   output mzc_pkg::mzc_apb_rsp_type      apb_rsp,
   input  wire logic               flash_rd_req,
   output logic                    flash_rd_ack,
   output logic [2:0]              flash_wait_count,
   output logic                    ram0_ecc_enable,
   output logic [9:0]              zero_start,
   input  wire logic [9:0]         zero_done,
   output logic [9:0]              zero_busy,
   output logic                    irq
);
   import mzc_pkg::*;

   mzc_regs_type s_reg;
   mzc_regs_type s_next;

   logic        access_ph;
   logic        commit;
   logic        wr_commit;
   logic        hit_ctrl;
   logic        hit_zero;
   logic        hit_stat;
   logic        hit_clr;
   logic        hit_en;
   logic        hit_any;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] rd_word;
   logic [9:0]  zero_wr1;
   logic [9:0]  clr_wr1;
   logic [9:0]  busy_n;
   logic [9:0]  start_n;
   logic [9:0]  stat_n;

   // First access cycle answers next edge; the write lands on the edge pready is seen
   assign access_ph = apb_req.psel & apb_req.penable & ~s_reg.rsp.pready;
   assign commit    = apb_req.psel & apb_req.penable & s_reg.rsp.pready;
   assign wr_commit = commit & apb_req.pwrite & hit_any;

   assign hit_ctrl = (apb_req.paddr[11:2] == OFF_MEM_CLOCK_CONTROL[11:2]);
   assign hit_zero = (apb_req.paddr[11:2] == OFF_MEM_ZEROIZE[11:2]);
   assign hit_stat = (apb_req.paddr[11:2] == OFF_INT_STATUS[11:2]);
   assign hit_clr  = (apb_req.paddr[11:2] == OFF_INT_CLEAR[11:2]);
   assign hit_en   = (apb_req.paddr[11:2] == OFF_INT_ENABLE[11:2]);
   assign hit_any  = hit_ctrl | hit_zero | hit_stat | hit_clr | hit_en;

   assign wmask = {{8{apb_req.pstrb[3]}},
                   {8{apb_req.pstrb[2]}},
                   {8{apb_req.pstrb[1]}},
                   {8{apb_req.pstrb[0]}}};
   assign wbits = apb_req.pwdata & wmask;

   assign zero_wr1 = (wr_commit & hit_zero) ? wbits[ZERO_LSB +: ZERO_N] : 10'h000;
   assign clr_wr1  = (wr_commit & hit_clr) ? wbits[ZERO_LSB +: ZERO_N] : 10'h000;

   // Reserved bits read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_word[WAIT_LSB +: WAIT_W] = s_reg.wait_count;
         rd_word[ECC_BIT]            = s_reg.ecc_en;
      end else if (hit_zero) begin
         rd_word[ZERO_LSB +: ZERO_N] = s_reg.zero_busy;
      end else if (hit_stat) begin
         rd_word[ZERO_LSB +: ZERO_N] = s_reg.int_status;
      end else if (hit_en) begin
         rd_word[ZERO_LSB +: ZERO_N] = s_reg.int_enable;
      end
   end

   // One memory per bit; a done pulse from an idle memory is ignored
   genvar gi;
   generate
      for (gi = 0; gi < ZERO_N; gi++) begin : g_zero
         always_comb begin
            busy_n[gi]  = s_reg.zero_busy[gi];
            start_n[gi] = 1'b0;
            if (s_reg.zero_busy[gi]) begin
               if (zero_done[gi]) begin
                  busy_n[gi] = 1'b0;
               end
            end else if (zero_wr1[gi]) begin
               busy_n[gi]  = 1'b1;
               start_n[gi] = 1'b1;
            end
            // Set wins over a clear arriving in the same cycle
            stat_n[gi] = s_reg.int_status[gi];
            if (clr_wr1[gi]) begin
               stat_n[gi] = 1'b0;
            end
            if (s_reg.zero_busy[gi] & zero_done[gi]) begin
               stat_n[gi] = 1'b1;
            end
         end
      end
   endgenerate

   always_comb begin
      s_next                = s_reg;
      s_next.zero_busy      = busy_n;
      s_next.zero_start     = start_n;
      s_next.int_status     = stat_n;
      s_next.rsp.pready     = access_ph;
      if (access_ph) begin
         s_next.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_word;
         s_next.rsp.pslverr = ~hit_any;
      end else begin
         s_next.rsp.pslverr = 1'b0;
      end
      if (wr_commit & hit_ctrl) begin
         if (apb_req.pstrb[0]) begin
            s_next.wait_count = apb_req.pwdata[WAIT_LSB +: WAIT_W];
         end
         if (apb_req.pstrb[2]) begin
            s_next.ecc_en = apb_req.pwdata[ECC_BIT];
         end
      end
      if (wr_commit & hit_en) begin
         s_next.int_enable = (s_reg.int_enable & ~wmask[ZERO_LSB +: ZERO_N])
                           | wbits[ZERO_LSB +: ZERO_N];
      end
      s_next.irq = |(s_next.int_status & s_next.int_enable);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg.wait_count  <= RST_WAIT_COUNT;
         s_reg.ecc_en      <= RST_ECC_EN;
         s_reg.zero_busy   <= RST_ZERO;
         s_reg.zero_start  <= RST_ZERO;
         s_reg.int_status  <= RST_ZERO;
         s_reg.int_enable  <= RST_ZERO;
         s_reg.irq         <= 1'b0;
         s_reg.rsp.prdata  <= 32'h0000_0000;
         s_reg.rsp.pready  <= 1'b0;
         s_reg.rsp.pslverr <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Software owns the oscillator-dependent minimum; no clamp here
   mzc_flash_wait u_flash_wait (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .wait_count (s_reg.wait_count),
      .rd_req     (flash_rd_req),
      .rd_ack     (flash_rd_ack)
   );

   assign apb_rsp          = s_reg.rsp;
   assign flash_wait_count = s_reg.wait_count;
   assign ram0_ecc_enable  = s_reg.ecc_en;
   assign zero_start       = s_reg.zero_start;
   assign zero_busy        = s_reg.zero_busy;
   assign irq              = s_reg.irq;

endmodule : mzc_top

// file: hdl/mzc_pkg.sv
// How it works
// - Every program-flash read waits the number of cycles in flash_wait_count, 0 to 7.
// - flash_wait_count resets to five wait states.
// - ram0_ecc_enable, bit 16, resets to zero and switches bank 0 error correction.
// - Writing one to a zeroize bit starts clearing the matching memory.
// - Hardware clears each zeroize bit when its memory is done; bits reset to zero.
// - A zeroize bit reads one while clearing runs and zero once it completes.
package mzc_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   localparam logic [11:0] OFF_MEM_CLOCK_CONTROL = 12'h028;
   localparam logic [11:0] OFF_MEM_ZEROIZE       = 12'h02C;
   localparam logic [11:0] OFF_INT_STATUS        = 12'h030;
   localparam logic [11:0] OFF_INT_CLEAR         = 12'h034;
   localparam logic [11:0] OFF_INT_ENABLE        = 12'h038;

   localparam int unsigned WAIT_LSB   = 0;
   localparam int unsigned WAIT_W     = 3;
   localparam int unsigned ECC_BIT    = 16;
   localparam int unsigned ZERO_LSB   = 2;
   localparam int unsigned ZERO_N     = 10;

   localparam logic [2:0] RST_WAIT_COUNT = 3'h5;
   localparam logic       RST_ECC_EN     = 1'b0;
   localparam logic [9:0] RST_ZERO       = 10'h000;

   // Zeroize bit index (bit position minus ZERO_LSB) of six of the ten memories
   localparam int unsigned Z_SYSTEM_BANK2 = 0;
   localparam int unsigned Z_SYSTEM_BANK7 = 5;
   localparam int unsigned Z_ECC_CHECK    = 6;
   localparam int unsigned Z_CODE_CACHE0  = 7;
   localparam int unsigned Z_CODE_CACHE1  = 8;
   localparam int unsigned Z_USB_RAM      = 9;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } mzc_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } mzc_apb_rsp_type;

   typedef enum logic [1:0] {
      FW_IDLE,
      FW_WAIT,
      FW_DONE
   } mzc_fw_state_type;

   typedef struct packed {
      mzc_fw_state_type state;
      logic [2:0]       count;
      logic             ack;
   } mzc_fw_regs_type;

   typedef struct packed {
      logic [2:0]      wait_count;
      logic            ecc_en;
      logic [9:0]      zero_busy;
      logic [9:0]      zero_start;
      logic [9:0]      int_status;
      logic [9:0]      int_enable;
      logic            irq;
      mzc_apb_rsp_type rsp;
   } mzc_regs_type;

endpackage : mzc_pkg

// file: hdl/mzc_flash_wait.sv
`timescale 1ns/1ns
module mzc_flash_wait (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [2:0] wait_count,
   input  wire logic       rd_req,
   output logic            rd_ack
);
   import mzc_pkg::*;

   mzc_fw_regs_type r_reg;
   mzc_fw_regs_type r_next;

   // Count is latched at the start of a read so a rewrite mid-access cannot tear it
   always_comb begin
      r_next     = r_reg;
      r_next.ack = 1'b0;
      case (r_reg.state)
         FW_IDLE: begin
            if (rd_req) begin
               if (wait_count == 3'h0) begin
                  r_next.ack   = 1'b1;
                  r_next.state = FW_DONE;
               end else begin
                  r_next.count = wait_count;
                  r_next.state = FW_WAIT;
               end
            end
         end
         FW_WAIT: begin
            r_next.count = r_reg.count - 3'h1;
            if (r_reg.count == 3'h1) begin
               r_next.ack   = 1'b1;
               r_next.state = FW_DONE;
            end
         end
         FW_DONE: begin
            r_next.state = FW_IDLE;
         end
         default: begin
            r_next.state = FW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r_reg.state <= FW_IDLE;
         r_reg.count <= 3'h0;
         r_reg.ack   <= 1'b0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rd_ack = r_reg.ack;

endmodule : mzc_flash_wait

// file: tb/mzc_props.sv
`timescale 1ns/1ns
module mzc_props (
   input wire logic                     clk_sys,
   input wire logic                     rst,
   input wire mzc_pkg::mzc_apb_req_type apb_req,
   input wire mzc_pkg::mzc_apb_rsp_type apb_rsp,
   input wire logic                     flash_rd_req,
   input wire logic                     flash_rd_ack,
   input wire logic [2:0]               flash_wait_count,
   input wire logic                     ram0_ecc_enable,
   input wire logic [9:0]               zero_start,
   input wire logic [9:0]               zero_done,
   input wire logic [9:0]               zero_busy,
   input wire logic                     irq
);
   import mzc_pkg::*;
   logic       cfg_wr;
   logic [9:0] done_hit;
   // Helper nets keep sampled-value calls on plain signals, except $changed on the config concatenation
   assign cfg_wr   = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
                     && apb_req.paddr == OFF_MEM_CLOCK_CONTROL;
   assign done_hit = zero_done & zero_busy;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_reset_vals:
      assert property ($past(rst) |-> flash_wait_count == 3'h5 && !ram0_ecc_enable
         && zero_busy == 10'h000) else $error("reset values wrong");
   a_ack_zero:
      assert property ($rose(flash_rd_req) && flash_wait_count == 3'h0 |=> flash_rd_ack)
         else $error("zero wait read not acked next cycle");
   a_ack_bound:
      assert property ($rose(flash_rd_req) |-> ##[1:8] flash_rd_ack)
         else $error("flash read not acked within eight cycles");
   a_ack_pulse:
      assert property (flash_rd_ack |=> !flash_rd_ack) else $error("ack longer than one cycle");
   a_start_pulse:
      assert property (zero_start != 10'h000 |=> zero_start == 10'h000)
         else $error("start pulse too long");
   a_busy_rise:
      assert property ((zero_busy & ~$past(zero_busy)) == zero_start)
         else $error("busy rise does not match start");
   a_done_clears:
      assert property (done_hit != 10'h000
         |=> (zero_busy & $past(done_hit)) == 10'h000)
         else $error("busy kept after done");
   a_busy_hold:
      assert property (($past(zero_busy) & ~zero_busy & ~$past(zero_done)) == 10'h000)
         else $error("busy dropped without done");
   a_cfg_write:
      assert property ($changed({flash_wait_count, ram0_ecc_enable}) |-> $past(cfg_wr))
         else $error("config changed without write");
endmodule : mzc_props
bind mzc_top mzc_props CHK (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .flash_rd_req(flash_rd_req), .flash_rd_ack(flash_rd_ack),
   .flash_wait_count(flash_wait_count), .ram0_ecc_enable(ram0_ecc_enable),
   .zero_start(zero_start), .zero_done(zero_done), .zero_busy(zero_busy), .irq(irq));

// file: tb/mzc_mem_model.sv
`timescale 1ns/1ns
module mzc_mem_model (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       slow,
   input  wire logic [9:0] zero_start,
   output logic [9:0]      zero_done
);
   logic [3:0] cnt_reg [10];
   // One counter per memory, so banks may finish in any order
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 10; i++) begin
         zero_done[i] <= 1'b0;
         if (rst)
            cnt_reg[i] <= 4'h0;
         else if (zero_start[i])
            cnt_reg[i] <= slow ? 4'hA : 4'h1;
         else if (cnt_reg[i] != 4'h0) begin
            cnt_reg[i] <= cnt_reg[i] - 4'h1;
            zero_done[i] <= (cnt_reg[i] == 4'h1);
         end
      end
   end
endmodule : mzc_mem_model

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   import mzc_pkg::*;
   logic            clk_sys = 1'b0;
   logic            rst = 1'b1;
   logic            slow = 1'b0;
   logic            flash_rd_req = 1'b0;
   mzc_apb_req_type apb_req = '0;
   mzc_apb_rsp_type apb_rsp;
   logic            flash_rd_ack, ram0_ecc_enable, irq, e;
   logic [2:0]      flash_wait_count;
   logic [9:0]      zero_start, zero_done, zero_busy;
   logic [31:0]     q;
   int              err_total = 0;
   int              checks_done = 0;
   always #2 clk_sys = ~clk_sys;
   mzc_top DUT (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .flash_rd_req(flash_rd_req), .flash_rd_ack(flash_rd_ack),
      .flash_wait_count(flash_wait_count), .ram0_ecc_enable(ram0_ecc_enable),
      .zero_start(zero_start), .zero_done(zero_done), .zero_busy(zero_busy), .irq(irq));
   mzc_mem_model MEM (.clk_sys(clk_sys), .rst(rst), .slow(slow), .zero_start(zero_start),
      .zero_done(zero_done));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Leading edge keeps release and next setup in separate time steps
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      apb_req <= '{1'b1, 1'b0, wr, a, d, 4'hF};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb
   task automatic flash(input logic [2:0] n);
      int c;
      c = 0;
      apb(1'b1, OFF_MEM_CLOCK_CONTROL, {29'h0, n});
      flash_rd_req <= 1'b1;
      do begin
         @(posedge clk_sys);
         c++;
      end while (flash_rd_ack !== 1'b1 && c < 20);
      flash_rd_req <= 1'b0;
      check(c, {29'h0, n} + 32'h2);
   endtask : flash
   task automatic poll_zero;
      int k;
      k = 0;
      do apb(1'b0, OFF_MEM_ZEROIZE, 32'h0); while (q !== 32'h0 && ++k < 30);
      check(q, 32'h0);
   endtask : poll_zero
   task automatic t_reset;
      apb(1'b0, OFF_MEM_CLOCK_CONTROL, 32'h0);
      check(q, 32'h5);
      apb(1'b0, OFF_MEM_ZEROIZE, 32'h0);
      check(q, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_config;
      apb(1'b1, OFF_MEM_CLOCK_CONTROL, 32'hFFFFFFFF);
      apb(1'b0, OFF_MEM_CLOCK_CONTROL, 32'h0);
      check(q, 32'h00010007);
      check(ram0_ecc_enable, 1'b1);
      flash(3'h0);
      flash(3'h2);
      flash(3'h7);
      check({29'h0, flash_wait_count}, 32'h7);
      check(ram0_ecc_enable, 1'b0);
      $display("t_config done");
   endtask : t_config
   task automatic t_zeroize;
      slow <= 1'b1;
      apb(1'b1, OFF_INT_ENABLE, 32'hFFC);
      apb(1'b1, OFF_MEM_ZEROIZE, 32'h0);
      apb(1'b0, OFF_MEM_ZEROIZE, 32'h0);
      check(q, 32'h0);
      apb(1'b1, OFF_MEM_ZEROIZE, 32'hFFFFFFFF);
      apb(1'b0, OFF_MEM_ZEROIZE, 32'h0);
      check(q, 32'hFFC);
      poll_zero;
      check(irq, 1'b1);
      apb(1'b0, OFF_INT_STATUS, 32'h0);
      check(q, 32'hFFC);
      apb(1'b1, OFF_INT_CLEAR, 32'hFFC);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b0);
      $display("t_zeroize done");
   endtask : t_zeroize
   task automatic t_mask;
      slow <= 1'b0;
      apb(1'b1, OFF_INT_ENABLE, 32'h0);
      apb(1'b1, OFF_MEM_ZEROIZE, 32'h4);
      poll_zero;
      apb(1'b0, OFF_INT_STATUS, 32'h0);
      check(q, 32'h4);
      check(irq, 1'b0);
      apb(1'b0, 12'h100, 32'h0);
      check({31'h0, e}, 32'h1);
      check(q, 32'h0);
      $display("t_mask done");
   endtask : t_mask
   task automatic finish_test;
      $display("Checks %0d, errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_config;
      t_zeroize;
      t_mask;
      finish_test;
   end
   initial begin
      repeat (4000) @(posedge clk_sys);
      err_total++;
      finish_test;
   end
endmodule : testbench
